// File: design/crsb_consts.svh
/*
 * constants of the capture channel that feeds the routing unit:
 * register offsets, field positions, reset values and timing counts.
 * assumes it is included by bare name by the package only; the design file relies on that include.
 */
`ifndef CRSB_CONSTS_SVH
`define CRSB_CONSTS_SVH

// ==========================================================================
// clock and timing
// ==========================================================================
`define CRSB_CLK_MHZ 20
`define CRSB_ROUNDTRIP_NS 100
// least time: round up to whole cycles
`define CRSB_ROUNDTRIP_CYC ((`CRSB_ROUNDTRIP_NS * `CRSB_CLK_MHZ + 999) / 1000)

// ==========================================================================
// register byte addresses
// ==========================================================================
`define CRSB_ADDR_W 8
`define CRSB_OFS_CTRL 8'h00
`define CRSB_OFS_NOTIFY 8'h04
`define CRSB_OFS_TOUT 8'h08
`define CRSB_OFS_STAT 8'h0c

// ==========================================================================
// field positions
// ==========================================================================
`define CRSB_CTRL_SEND_EN 0
`define CRSB_CTRL_SELA_LO 1
`define CRSB_CTRL_SELB_LO 3
`define CRSB_CTRL_CADDR_LO 8
`define CRSB_NTF_CAP 0
`define CRSB_NTF_OVF 3
`define CRSB_NTF_TOUT 4
`define CRSB_STAT_PEND 8
`define CRSB_STAT_LVL 9
`define CRSB_ST_LVL 0
`define CRSB_ST_OVF 1
`define CRSB_ST_TOUT 2
`define CRSB_WORD_LVL 23

// ==========================================================================
// sizes and reset values
// ==========================================================================
`define CRSB_WORD_W 24
`define CRSB_FIFO_DEPTH 16
`define CRSB_NTF_RST 5'h00
`define CRSB_TOUT_RST 24'h000000

`endif

// File: design/crsb_pkg.sv
/*
 * types shared by the capture channel and its routing fifo.
 * assumes crsb_consts.svh is on the include path.
 */
`include "crsb_consts.svh"

package crsb_pkg;

    // ======================================================================
    // data source of a transferred word
    // ======================================================================
    typedef enum logic [1:0]
    {
        CRSB_SRC_EDGE = 2'b00, // edge_counter with level on top
        CRSB_SRC_TSTAMP = 2'b01, // free running time stamp
        CRSB_SRC_LEVEL = 2'b10, // input_level_value
        CRSB_SRC_DUR = 2'b11 // cycles since last edge
    } crsb_src_e;

    // channel control fields
    typedef struct packed
    {
        logic [7:0] caddr; // channel address for dynamic routing
        crsb_src_e sel_b; // data_word_select of word b
        crsb_src_e sel_a; // data_word_select of word a
        logic send_en; // routing send enable
    } crsb_ctrl_s;

    // one transfer: two words and the route_status_bits
    typedef struct packed
    {
        logic [`CRSB_WORD_W-1:0] word_a;
        logic [`CRSB_WORD_W-1:0] word_b;
        logic [2:0] status; // timeout, overflow, level
    } crsb_xfer_s;

endpackage

// File: design/crsb_capture.sv
/*
 * input_capture_channel with routing request logic, a 16 word fifo toward
 * the routing unit, a registered output stage and the debug_route_valid
 * strobe. also holds the fifo module.
 * assumes one 20 MHz clock, a synchronous input level and a plain register
 * port whose read data stand one cycle after the read strobe.
 */
// Behaviour
// - raise requests only while send enable set
// - serve request after one round-trip time
// - status bits flag overflow and timeout events
// - status bits survive clock ratio, always carried
// - late capture shows new level bit
// - late capture updates overflow and words consistently
// - level embedded in edge and level words
// - back-to-back words on one address never lost
// - debug strobe once per routed transfer
// - overflow and timeout readable in notify bits
`timescale 1ns/100ps

// ==========================================================================
// fifo
// ==========================================================================
module crsb_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [WIDTH-1:0] i_wdata,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [WIDTH-1:0] o_rdata,
    output logic [$clog2(DEPTH):0] o_count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH]; // storage flops
    logic [AW-1:0] wr_ptr_r; // next entry to fill
    logic [AW-1:0] rd_ptr_r; // oldest entry
    logic [AW:0] cnt_r; // words held
    logic push; // word taken
    logic pop; // word drained

    assign o_wready = (cnt_r != (AW+1)'(DEPTH));
    assign o_rvalid = (cnt_r != '0);
    assign o_rdata = mem_r[rd_ptr_r];
    assign o_count = cnt_r;
    assign push = i_wvalid && o_wready;
    assign pop = o_rvalid && i_rready;

    // storage write
    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= i_wdata;
        end
    end

    // pointers and fill level
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_r <= cnt_r + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

// ==========================================================================
// capture channel top
// ==========================================================================
module crsb_capture
import crsb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_sig,
    input wire logic [`CRSB_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_route_valid,
    output crsb_xfer_s o_route_data,
    output logic [7:0] o_route_addr,
    input wire logic i_route_ready,
    output logic o_dbg_valid
);
    localparam int FAW = $clog2(`CRSB_FIFO_DEPTH);
    localparam logic [3:0] RT_CYC = 4'(`CRSB_ROUNDTRIP_CYC);

    crsb_ctrl_s ctrl_r; // channel control
    logic [4:0] notify_r; // event_notify_register
    logic [4:0] notify_nxt;
    logic [`CRSB_WORD_W-1:0] tout_r; // timeout limit, zero disables
    logic [31:0] rdata_r; // read data, one cycle after strobe
    logic sig_d_r; // previous input level
    logic [`CRSB_WORD_W-1:0] edge_counter_r; // edge_counter
    logic [`CRSB_WORD_W-1:0] tstamp_r; // free running time stamp
    logic [`CRSB_WORD_W-1:0] dur_r; // cycles since last edge
    logic cap_evt; // new capture event
    logic tout_evt; // timeout event
    logic any_evt;
    logic req_pend_r; // transfer request raised
    logic [3:0] rt_cnt_r; // round-trip wait
    crsb_xfer_s req_r; // pending transfer
    crsb_xfer_s req_nxt;
    logic req_push; // request acknowledged into fifo
    logic fifo_wready;
    logic fifo_rvalid;
    logic fifo_rready;
    crsb_xfer_s fifo_rdata;
    logic [FAW:0] fifo_cnt;
    logic out_valid_r; // output stage holds a word
    crsb_xfer_s out_data_r;
    logic dbg_r; // debug_route_valid
    logic reg_hit_ctrl;
    logic reg_hit_ntf;

    assign reg_hit_ctrl = (i_addr == `CRSB_OFS_CTRL);
    assign reg_hit_ntf = (i_addr == `CRSB_OFS_NOTIFY);

    // ======================================================================
    // event detection
    // ======================================================================
    assign cap_evt = i_sig ^ sig_d_r;
    assign tout_evt = (tout_r != '0) && (dur_r == tout_r) && !cap_evt;
    assign any_evt = cap_evt || tout_evt;

    // data word source mux, level embedded in edge and level words
    function automatic logic [`CRSB_WORD_W-1:0] src_word(input crsb_src_e sel,
        input logic lvl, input logic [`CRSB_WORD_W-1:0] edge_counter,
        input logic [`CRSB_WORD_W-1:0] ts, input logic [`CRSB_WORD_W-1:0] dur);
        logic [`CRSB_WORD_W-1:0] w;
        w = '0;
        unique case (sel)
            CRSB_SRC_EDGE: w = {lvl, edge_counter[`CRSB_WORD_W-2:0]};
            CRSB_SRC_TSTAMP: w = ts;
            CRSB_SRC_LEVEL: w = {{(`CRSB_WORD_W-1){1'b0}}, lvl};
            CRSB_SRC_DUR: w = dur;
        endcase
        return w;
    endfunction

    // edge counter, time stamp and duration counters
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sig_d_r <= 1'b0;
            edge_counter_r <= '0;
            tstamp_r <= '0;
            dur_r <= '0;
        end
        else
        begin
            sig_d_r <= i_sig;
            tstamp_r <= tstamp_r + 1'b1;
            if (cap_evt)
            begin
                edge_counter_r <= edge_counter_r + 1'b1;
                dur_r <= '0;
            end
            else if (dur_r != '1)
            begin
                dur_r <= dur_r + 1'b1; // saturates, no false second timeout unless the limit is all ones
            end
        end
    end

    // ======================================================================
    // transfer request
    // ======================================================================
    assign req_push = req_pend_r && (rt_cnt_r == 4'h0) && fifo_wready;

    // snapshot of one event: words and status built from the same cycle
    always_comb
    begin
        req_nxt.word_a = src_word(ctrl_r.sel_a, i_sig, edge_counter_r, tstamp_r, dur_r);
        req_nxt.word_b = src_word(ctrl_r.sel_b, i_sig, edge_counter_r, tstamp_r, dur_r);
        req_nxt.status[`CRSB_ST_LVL] = i_sig;
        // a still pending request makes this event an overflow
        req_nxt.status[`CRSB_ST_OVF] = req_pend_r && !req_push;
        req_nxt.status[`CRSB_ST_TOUT] = tout_evt ||
            (req_r.status[`CRSB_ST_TOUT] && req_pend_r && !req_push);
    end

    // pending request: a late event replaces the whole bundle at once
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            req_pend_r <= 1'b0;
            rt_cnt_r <= 4'h0;
            req_r <= '0;
        end
        else if (!ctrl_r.send_en)
        begin
            req_pend_r <= 1'b0;
        end
        else if (any_evt)
        begin
            req_pend_r <= 1'b1;
            req_r <= req_nxt;
            if (!req_pend_r || req_push)
            begin
                rt_cnt_r <= RT_CYC;
            end
            else if (rt_cnt_r != 4'h0)
            begin
                rt_cnt_r <= rt_cnt_r - 1'b1;
            end
        end
        else if (req_push)
        begin
            req_pend_r <= 1'b0;
        end
        else if (req_pend_r && rt_cnt_r != 4'h0)
        begin
            rt_cnt_r <= rt_cnt_r - 1'b1;
        end
    end

    // ======================================================================
    // fifo and output stage
    // ======================================================================
    crsb_fifo #(.WIDTH($bits(crsb_xfer_s)), .DEPTH(`CRSB_FIFO_DEPTH)) u_fifo
    (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_wvalid(req_push),
        .o_wready(fifo_wready),
        .i_wdata(req_r),
        .o_rvalid(fifo_rvalid),
        .i_rready(fifo_rready),
        .o_rdata(fifo_rdata),
        .o_count(fifo_cnt)
    );

    // stage refills in the same cycle it drains: full rate on one address
    assign fifo_rready = !out_valid_r || i_route_ready;

    // registered output stage and debug strobe
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            out_valid_r <= 1'b0;
            out_data_r <= '0;
            dbg_r <= 1'b0;
        end
        else
        begin
            if (fifo_rready)
            begin
                out_valid_r <= fifo_rvalid;
                out_data_r <= fifo_rdata;
            end
            dbg_r <= out_valid_r && i_route_ready;
        end
    end

    assign o_route_valid = out_valid_r;
    assign o_route_data = out_data_r;
    assign o_route_addr = ctrl_r.caddr;
    assign o_dbg_valid = dbg_r;

    // ======================================================================
    // registers
    // ======================================================================
    // notify: hardware set wins over write-one clear
    always_comb
    begin
        notify_nxt = notify_r;
        if (i_wr && reg_hit_ntf)
        begin
            notify_nxt = notify_r & ~i_wdata[4:0];
        end
        notify_nxt[`CRSB_NTF_CAP] = notify_nxt[`CRSB_NTF_CAP] | cap_evt;
        notify_nxt[`CRSB_NTF_OVF] = notify_nxt[`CRSB_NTF_OVF] |
            (any_evt && req_pend_r && !req_push);
        notify_nxt[`CRSB_NTF_TOUT] = notify_nxt[`CRSB_NTF_TOUT] | tout_evt;
    end

    // control, notify and timeout storage
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ctrl_r <= '0;
            notify_r <= `CRSB_NTF_RST;
            tout_r <= `CRSB_TOUT_RST;
        end
        else
        begin
            notify_r <= notify_nxt;
            if (i_wr && reg_hit_ctrl)
            begin
                ctrl_r <= crsb_ctrl_s'({i_wdata[15:8], i_wdata[4:0]}); // bits 7:5 dropped
            end
            if (i_wr && (i_addr == `CRSB_OFS_TOUT))
            begin
                tout_r <= i_wdata[`CRSB_WORD_W-1:0];
            end
        end
    end

    // read data: only in the cycle after the strobe, zero otherwise
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rdata_r <= 32'h0;
        end
        else if (!i_rd)
        begin
            rdata_r <= 32'h0;
        end
        else
        begin
            unique case (i_addr)
                `CRSB_OFS_CTRL: rdata_r <= {16'h0, ctrl_r.caddr, 3'h0, ctrl_r[4:0]};
                `CRSB_OFS_NOTIFY: rdata_r <= {27'h0, notify_r};
                `CRSB_OFS_TOUT: rdata_r <= {8'h0, tout_r};
                `CRSB_OFS_STAT: rdata_r <= {22'h0, sig_d_r, req_pend_r, 3'h0, fifo_cnt};
                default: rdata_r <= 32'h0; // unmapped
            endcase
        end
    end

    assign o_rdata = rdata_r;

    // ======================================================================
    // assertions
    // ======================================================================
    property p_off_no_req;
        @(posedge i_clk) disable iff (!i_rst_b)
        !ctrl_r.send_en |=> !req_pend_r;
    endproperty
    a_off_no_req: assert property (p_off_no_req)
        else $error("request pending while send disabled");

    property p_roundtrip;
        @(posedge i_clk) disable iff (!i_rst_b)
        $rose(req_pend_r) |-> !req_push ##1 !req_push;
    endproperty
    a_roundtrip: assert property (p_roundtrip)
        else $error("request served before round trip");

    property p_ovf_bit;
        @(posedge i_clk) disable iff (!i_rst_b)
        ctrl_r.send_en && any_evt && req_pend_r && !req_push |=> req_r.status[1];
    endproperty
    a_ovf_bit: assert property (p_ovf_bit)
        else $error("overflow status bit missing");

    property p_tout_bit;
        @(posedge i_clk) disable iff (!i_rst_b)
        ctrl_r.send_en && tout_evt |=> req_pend_r && req_r.status[2];
    endproperty
    a_tout_bit: assert property (p_tout_bit)
        else $error("timeout status bit missing");

    property p_late_level;
        @(posedge i_clk) disable iff (!i_rst_b)
        ctrl_r.send_en && cap_evt |=> req_r.status[0] == $past(i_sig);
    endproperty
    a_late_level: assert property (p_late_level)
        else $error("level bit not the new level");

    property p_late_words;
        @(posedge i_clk) disable iff (!i_rst_b)
        ctrl_r.send_en && any_evt |=> req_r.word_a == $past(req_nxt.word_a)
            && req_r.word_b == $past(req_nxt.word_b);
    endproperty
    a_late_words: assert property (p_late_words)
        else $error("data words not from the new event");

    property p_embed_level;
        @(posedge i_clk) disable iff (!i_rst_b)
        ctrl_r.send_en && cap_evt && ctrl_r.sel_a == CRSB_SRC_EDGE
            |=> req_r.word_a[23] == req_r.status[0];
    endproperty
    a_embed_level: assert property (p_embed_level)
        else $error("embedded level differs from level bit");

    property p_hold_out;
        @(posedge i_clk) disable iff (!i_rst_b)
        out_valid_r && !i_route_ready |=> out_valid_r && $stable(out_data_r);
    endproperty
    a_hold_out: assert property (p_hold_out)
        else $error("stalled word dropped or changed");

    property p_refill;
        @(posedge i_clk) disable iff (!i_rst_b)
        out_valid_r && i_route_ready && fifo_rvalid |=> out_valid_r;
    endproperty
    a_refill: assert property (p_refill)
        else $error("back-to-back word lost");

    property p_dbg;
        @(posedge i_clk) disable iff (!i_rst_b)
        (out_valid_r && i_route_ready) |=> dbg_r;
    endproperty
    a_dbg: assert property (p_dbg)
        else $error("debug strobe missing");

    property p_ntf_read;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_rd && reg_hit_ntf |=> rdata_r[4:3] == $past(notify_r[4:3]);
    endproperty
    a_ntf_read: assert property (p_ntf_read)
        else $error("notify bits read wrong");

    property p_bundle_in;
        @(posedge i_clk) disable iff (!i_rst_b)
        req_push && !fifo_rready |=> fifo_cnt == $past(fifo_cnt) + 1'b1;
    endproperty
    a_bundle_in: assert property (p_bundle_in)
        else $error("acknowledged transfer not stored");
endmodule

// File: testbench/crsb_route_sink.sv
/*
 * behavioural consumer on the routing side of the capture channel.
 * assumes the channel's single 20 MHz clock and its active low reset.
 */
`timescale 1ns/100ps

// ==========================================================================
// routing consumer model
// ==========================================================================
module crsb_route_sink
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [1:0] i_mode, // 0 prompt, 1 random stalls, 2 stalled
    output logic o_ready // accepts the offered transfer
);
    // ready changes only just after an edge, never while in reset
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_ready <= 1'b0;
        end
        else if (i_mode == 2'h0)
        begin
            o_ready <= 1'b1; // takes every word at full rate
        end
        else if (i_mode == 2'h1)
        begin
            o_ready <= 1'($urandom_range(1, 0)); // slow consumer
        end
        else
        begin
            o_ready <= 1'b0; // consumer busy elsewhere
        end
    end
endmodule

// File: testbench/crsb_capture_test.sv
/*
 * self-checking bench of the capture channel and its routing fifo.
 * assumes the design package and the routing consumer model are compiled first.
 */
`timescale 1ns/100ps

// ==========================================================================
// testbench top
// ==========================================================================
module crsb_capture_test
import crsb_pkg::*;
;
    logic i_clk, i_rst_b, i_sig, i_wr, i_rd; // design inputs
    logic route_ready, o_route_valid, o_dbg_valid; // link handshake
    logic [7:0] i_addr, o_route_addr, caddr_v; // addresses
    logic [31:0] i_wdata, o_rdata; // register data
    crsb_xfer_s o_route_data, prev_data; // offered transfer
    logic [1:0] sink_mode; // consumer behaviour
    logic [35:0] xq[$]; // expected transfers, oldest first
    logic prev_stall, dbg_exp, sig_v; // monitor state and input level
    int err_total, total_checks, hs_cnt, dbg_cnt, cyc, k;

    crsb_capture u_crsb_capture (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_sig(i_sig),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_route_valid(o_route_valid), .o_route_data(o_route_data),
        .o_route_addr(o_route_addr), .i_route_ready(route_ready), .o_dbg_valid(o_dbg_valid));

    crsb_route_sink u_crsb_route_sink (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_mode(sink_mode),
        .o_ready(route_ready));

    // ======================================================================
    // clock and hang guard
    // ======================================================================
    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // a run far beyond the planned length counts as a failure
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            summarize();
        end
    end

    // ======================================================================
    // shared tasks
    // ======================================================================
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // one-cycle write strobe
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // one-cycle read strobe, data looked at in the following cycle only
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        check({32'h0, o_rdata}, {32'h0, exp});
    endtask

    // a change of the input level is one capture event
    task automatic flip();
        @(posedge i_clk);
        i_sig <= ~sig_v;
        sig_v = ~sig_v;
    endtask

    // expected transfer: only the level bit on top of word a, word b level
    task automatic note(input logic tout, input logic ovf);
        xq.push_back({caddr_v, sig_v, 23'h0, sig_v, tout, ovf, sig_v});
    endtask

    task automatic drain(input int limit);
        for (int n = 0; n < limit && xq.size() > 0; n++)
            @(posedge i_clk);
    endtask

    // ======================================================================
    // monitor: handshakes, debug strobe and held data
    // ======================================================================
    always @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            prev_stall = 1'b0;
            dbg_exp = 1'b0;
        end
        else
        begin
            check({63'h0, o_dbg_valid}, {63'h0, dbg_exp});
            if (prev_stall)
                check({12'h0, o_route_valid, o_route_data}, {12'h0, 1'b1, prev_data});
            dbg_exp = o_route_valid & route_ready;
            prev_stall = o_route_valid & ~route_ready;
            prev_data = o_route_data;
            if (o_dbg_valid)
                dbg_cnt++;
            if (dbg_exp)
            begin
                hs_cnt++;
                if (xq.size() == 0)
                    check(64'h1, 64'h0);
                else
                    check({28'h0, o_route_addr, o_route_data.word_a[23], o_route_data.word_b,
                        o_route_data.status}, {28'h0, xq.pop_front()});
            end
        end
    end

    // ======================================================================
    // main sequence
    // ======================================================================
    initial
    begin
        i_rst_b = 1'b0;
        i_sig = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        sink_mode = 2'h0;
        sig_v = 1'b0;
        caddr_v = 8'($urandom(32'h8b2c7ead));
        repeat (20) @(posedge i_clk);
        i_rst_b <= 1'b1;
        // reset values, unmapped address included
        for (int a = 0; a < 20; a += 4)
            reg_rd(8'(a), 32'h0);
        // send disabled: event recorded, nothing offered
        reg_wr(8'h00, {16'h0, caddr_v, 8'h10});
        reg_rd(8'h00, {16'h0, caddr_v, 8'h10});
        flip();
        repeat (10) @(posedge i_clk);
        reg_rd(8'h04, 32'h01);
        reg_wr(8'h04, 32'h1f);
        reg_rd(8'h04, 32'h00);
        // send enabled: single event, then a late event while pending
        reg_wr(8'h00, {16'h0, caddr_v, 8'h11});
        flip();
        note(1'b0, 1'b0);
        repeat (10) @(posedge i_clk);
        flip();
        flip();
        note(1'b0, 1'b1);
        repeat (10) @(posedge i_clk);
        // event one cycle before the acknowledge replaces the bundle
        flip();
        @(posedge i_clk);
        flip();
        note(1'b0, 1'b1);
        repeat (10) @(posedge i_clk);
        // event in the acknowledge cycle starts a fresh request
        flip();
        note(1'b0, 1'b0);
        repeat (2) @(posedge i_clk);
        flip();
        note(1'b0, 1'b0);
        repeat (10) @(posedge i_clk);
        reg_rd(8'h04, 32'h09);
        reg_wr(8'h04, 32'h1f);
        // timeout after a quiet period of 20 cycles
        repeat (30) @(posedge i_clk);
        reg_wr(8'h08, 32'd20);
        flip();
        note(1'b0, 1'b0);
        note(1'b1, 1'b0);
        repeat (60) @(posedge i_clk);
        reg_rd(8'h04, 32'h11);
        reg_wr(8'h08, 32'h0);
        reg_wr(8'h04, 32'h1f);
        // fill the fifo with the consumer stalled
        sink_mode <= 2'h2;
        for (int n = 0; n < 17; n++)
        begin
            flip();
            note(1'b0, 1'b0);
            k = $urandom_range(6, 3);
            repeat (k) @(posedge i_clk);
        end
        reg_rd(8'h0c, {22'h0, sig_v, 1'b0, 8'h10});
        flip();
        note(1'b0, 1'b0);
        repeat (6) @(posedge i_clk);
        reg_rd(8'h0c, {22'h0, sig_v, 1'b1, 8'h10});
        // drain back to back, then a burst against a slow consumer
        sink_mode <= 2'h0;
        drain(200);
        repeat (4) @(posedge i_clk);
        reg_rd(8'h0c, {22'h0, sig_v, 1'b0, 8'h00});
        sink_mode <= 2'h1;
        for (int n = 0; n < 8; n++)
        begin
            flip();
            note(1'b0, 1'b0);
            k = $urandom_range(6, 3);
            repeat (k) @(posedge i_clk);
        end
        drain(300);
        repeat (4) @(posedge i_clk);
        check(64'(dbg_cnt), 64'(hs_cnt));
        check(64'(xq.size()), 64'h0);
        summarize();
    end
endmodule
